// file: logic/pst_pkg.sv
// package for the program space table access block
// assumes one clock domain shared with the core's instruction sequencer
package pst_pkg;
  localparam int unsigned PST_ADDR_W     = 24;
  localparam int unsigned PST_PC_W       = 23;
  localparam int unsigned PST_WORD_W     = 24;
  localparam int unsigned PST_DATA_W     = 16;
  localparam int unsigned PST_PAGE_W     = 8;
  localparam int unsigned PST_VIS_LOW_W  = 15;
  localparam int unsigned PST_SPACE_BIT  = 23;
  localparam int unsigned PST_PAGE_SPACE = 7;
  localparam logic [23:0] PST_USER_MAX   = 24'h7ffffe;
  localparam logic [23:0] PST_ADDR_RST   = 24'h000000;
  localparam logic [15:0] PST_DATA_RST   = 16'h0000;
  localparam logic [7:0]  PST_BYTE_ZERO  = 8'h00;
  localparam logic [7:0]  PST_PAGE_RST   = 8'h00;

  typedef enum logic [2:0] {
    PST_OP_NONE  = 3'b000,
    PST_OP_FETCH = 3'b001,
    PST_OP_RDL   = 3'b010,
    PST_OP_RDH   = 3'b011,
    PST_OP_WTL   = 3'b100,
    PST_OP_WTH   = 3'b101,
    PST_OP_DATA  = 3'b110
  } pst_op_t;

  typedef enum logic [1:0] {
    PST_SRC_PC    = 2'b00,
    PST_SRC_TABLE = 2'b01,
    PST_SRC_VIS   = 2'b10,
    PST_SRC_NONE  = 2'b11
  } pst_src_t;
endpackage : pst_pkg

// file: logic/pst_lane_if.sv
// interface carrying the table data lanes between the top and the lane mapper
// assumes both ends on the same clock; purely combinational signals
interface pst_lane_if;
  import pst_pkg::*;
  logic [23:0] prog_word;
  logic [15:0] wr_data;
  logic        byte_mode;
  logic        byte_sel;
  logic        high_op;
  logic [15:0] rd_data;
  logic [23:0] wr_word;
  logic [2:0]  wr_lanes;
  modport top    (output prog_word, output wr_data, output byte_mode, output byte_sel,
                  output high_op, input rd_data, input wr_word, input wr_lanes);
  modport mapper (input prog_word, input wr_data, input byte_mode, input byte_sel,
                  input high_op, output rd_data, output wr_word, output wr_lanes);
endinterface : pst_lane_if

// file: logic/pst_lane_map.sv
// lane mapper: places program word bytes onto the data path and back
// assumes a settled program word and a decoded operation from the top
module pst_lane_map
  import pst_pkg::*;
(
  pst_lane_if.mapper lane
);
  wire [7:0] lo_byte   = lane.prog_word[7:0];
  wire [7:0] mid_byte  = lane.prog_word[15:8];
  wire [7:0] hi_byte   = lane.prog_word[23:16];
  wire [7:0] rdl_byte  = lane.byte_sel ? mid_byte : lo_byte;                 // [RULE9]
  wire [7:0] rdh_byte  = lane.byte_sel ? PST_BYTE_ZERO : hi_byte;            // [RULE11]
  wire [15:0] rdl_data = lane.byte_mode ? {PST_BYTE_ZERO, rdl_byte}
                                        : lane.prog_word[15:0];             // [RULE8]
  wire [15:0] rdh_data = lane.byte_mode ? {PST_BYTE_ZERO, rdh_byte}
                                        : {PST_BYTE_ZERO, hi_byte};         // [RULE10]
  // low ops see only the lsw space, high ops only the msb space
  assign lane.rd_data = lane.high_op ? rdh_data : rdl_data;                 // [RULE13]
  wire [7:0] wr_byte  = lane.wr_data[7:0];
  assign lane.wr_word = lane.high_op ? {wr_byte, lane.wr_data}
                                     : {PST_BYTE_ZERO, lane.wr_data};       // [RULE12]
  // low byte writes touch only the addressed lane; high writes take the upper lane for either byte select
  assign lane.wr_lanes = lane.high_op ? 3'b100 :
                         !lane.byte_mode ? 3'b011 :
                         lane.byte_sel ? 3'b010 : 3'b001;                   // [RULE13]
endmodule : pst_lane_map

// file: logic/pst_access.sv
// top of program space table access: address build and data path
// assumes core presents op, pc, table ea, data ea one cycle; memory answers same cycle
// Function
// RULE1: program space is 4M words reached by a 24-bit address.
// RULE2: address comes from pc, table ea, or visibility data ea.
// RULE3: successive program words step by two.
// RULE4: non-table accesses confined to 0x000000..0x7ffffe.
// RULE5: table page bit 7 picks user or configuration space for table ops.
// RULE6: bit 23 only set through table path; zero otherwise.
// RULE7: program words fetched whole, 24 bits, word aligned.
// RULE8: word read low returns program bits 15:0 on data 15:0.
// RULE9: byte read low returns bits 7:0 or 15:8 by byte select.
// RULE10: word read high puts bits 23:16 low, upper data byte zero.
// RULE11: byte read high returns bits 23:16, or zero for byte select one.
// RULE12: only high table ops reach the upper program byte.
// RULE13: program memory is two side by side 16-bit spaces.
// RULE14: a 16K-word page can be mapped into upper data space.
// RULE15: redirect only when data ea msb and visibility enable both set.
// RULE16: visibility maps 15 low ea bits; page register gives the rest.
// RULE17: visibility suspended during table read or write.
// RULE18: table page gives bits 23:16, table ea gives bits 15:0.
module pst_access
  import pst_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire pst_op_t     op_i,
  input  wire logic        byte_mode_i,
  input  wire logic [22:0] pc_i,
  input  wire logic [15:0] table_ea_i,
  input  wire logic [15:0] data_ea_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic [7:0]  table_page_register_i,
  input  wire logic [7:0]  visibility_page_register_i,
  input  wire logic        program_space_visibility_i,
  input  wire logic [23:0] prog_word_i,
  output logic      [23:0] prog_addr_o,
  output logic             prog_rd_o,
  output logic             prog_wr_o,
  output logic      [2:0]  prog_lanes_o,
  output logic      [23:0] prog_wdata_o,
  output logic             config_space_o,
  output logic      [15:0] rd_data_o,
  output logic             rd_valid_o,
  output logic             vis_hit_o,
  output logic             range_err_o
);
  pst_lane_if lane ();

  function automatic logic [23:0] pst_align(input logic [23:0] a);
    pst_align = {a[23:1], 1'b0};
  endfunction : pst_align

  wire is_table  = (op_i == PST_OP_RDL) || (op_i == PST_OP_RDH) ||
                   (op_i == PST_OP_WTL) || (op_i == PST_OP_WTH);
  wire is_write  = (op_i == PST_OP_WTL) || (op_i == PST_OP_WTH);
  wire is_high   = (op_i == PST_OP_RDH) || (op_i == PST_OP_WTH);
  wire is_fetch  = (op_i == PST_OP_FETCH);
  // visibility yields to any table op in the same cycle
  wire vis_req   = (op_i == PST_OP_DATA) && data_ea_i[15] && program_space_visibility_i
                   && !is_table;                                           // [RULE15] [RULE17]

  pst_src_t src;
  assign src = is_table ? PST_SRC_TABLE :
               is_fetch ? PST_SRC_PC    :
               vis_req  ? PST_SRC_VIS   : PST_SRC_NONE;                    // [RULE2]

  // pc counts in words; byte address is pc times two
  wire [23:0] pc_addr  = {pc_i, 1'b0};                                     // [RULE3] [RULE7]
  wire [23:0] tbl_addr = {table_page_register_i, table_ea_i};              // [RULE18] [RULE5]
  wire [23:0] vis_addr = {1'b0, visibility_page_register_i[7:0],
                          data_ea_i[PST_VIS_LOW_W-1:0]};                   // [RULE14] [RULE16]
  wire [23:0] raw_addr = (src == PST_SRC_TABLE) ? tbl_addr :
                         (src == PST_SRC_PC)    ? pc_addr  :
                         (src == PST_SRC_VIS)   ? vis_addr : PST_ADDR_RST;
  // bit 23 survives only on the table path
  wire        keep_top = (src == PST_SRC_TABLE);                           // [RULE6]
  wire [23:0] sel_addr = {raw_addr[PST_SPACE_BIT] & keep_top, raw_addr[22:0]};
  wire [23:0] word_addr = pst_align(sel_addr);                             // [RULE1] [RULE7]
  // range check looks before bit 23 is cleared, else a pc overflow aliases to page zero
  wire        over_user = !keep_top && (src != PST_SRC_NONE) &&
                          (pst_align(raw_addr) > PST_USER_MAX);            // [RULE4]

  assign lane.prog_word = prog_word_i;
  assign lane.wr_data   = wr_data_i;
  assign lane.byte_mode = byte_mode_i && is_table;
  assign lane.byte_sel  = table_ea_i[0];
  assign lane.high_op   = is_high;

  pst_lane_map u_lane (
    .lane (lane.mapper)
  );

  wire        rd_now   = (src != PST_SRC_NONE) && !is_write;
  wire [15:0] vis_data = prog_word_i[15:0];
  wire [15:0] rd_sel   = (src == PST_SRC_TABLE) ? lane.rd_data : vis_data;

  logic [23:0] addr_reg;
  logic        rd_reg;
  logic        wr_reg;
  logic [2:0]  lanes_reg;
  logic [23:0] wdata_reg;
  logic        cfg_reg;
  logic [15:0] data_reg;
  logic        valid_reg;
  logic        vis_reg;
  logic        err_reg;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      addr_reg  <= PST_ADDR_RST;
      rd_reg    <= 1'b0;
      wr_reg    <= 1'b0;
      lanes_reg <= 3'b000;
      wdata_reg <= PST_ADDR_RST;
      cfg_reg   <= 1'b0;
      data_reg  <= PST_DATA_RST;
      valid_reg <= 1'b0;
      vis_reg   <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      addr_reg  <= word_addr;
      rd_reg    <= rd_now && !over_user;
      wr_reg    <= is_write;
      lanes_reg <= is_write ? lane.wr_lanes : 3'b000;                     // [RULE12]
      wdata_reg <= is_write ? lane.wr_word : PST_ADDR_RST;
      cfg_reg   <= keep_top && table_page_register_i[PST_PAGE_SPACE];     // [RULE5]
      data_reg  <= (rd_now && !is_fetch) ? rd_sel : PST_DATA_RST;
      valid_reg <= rd_now && !is_fetch && !over_user;
      vis_reg   <= (src == PST_SRC_VIS);
      err_reg   <= over_user;
    end
  end

  assign prog_addr_o    = addr_reg;
  assign prog_rd_o      = rd_reg;
  assign prog_wr_o      = wr_reg;
  assign prog_lanes_o   = lanes_reg;
  assign prog_wdata_o   = wdata_reg;
  assign config_space_o = cfg_reg;
  assign rd_data_o      = data_reg;
  assign rd_valid_o     = valid_reg;
  assign vis_hit_o      = vis_reg;
  assign range_err_o    = err_reg;

  // address phase and data phase are both one cycle after the request
  a_top_bit_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE6]
    (op_i != PST_OP_NONE && !is_table) |=> !prog_addr_o[23])
    else $error("bit 23 set outside table path");
  a_cfg_select: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE5]
    is_table |=> (config_space_o == $past(table_page_register_i[7])))
    else $error("config space select wrong");
  a_table_addr: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE18]
    is_table |=> prog_addr_o[15:1] == $past(table_ea_i[15:1])
      && prog_addr_o[22:16] == $past(table_page_register_i[6:0]))
    else $error("table address wrong");
  a_pc_addr: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE3]
    is_fetch |=> prog_addr_o == {1'b0, $past(pc_i[21:0]), 1'b0} || range_err_o)
    else $error("fetch address wrong");
  a_vis_map: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE16]
    vis_req |=> vis_hit_o && prog_addr_o[14:1] == $past(data_ea_i[14:1])
      && prog_addr_o[22:15] == $past(visibility_page_register_i))
    else $error("visibility address wrong");
  a_vis_gate: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE15]
    (op_i == PST_OP_DATA && (!data_ea_i[15] || !program_space_visibility_i))
      |=> !vis_hit_o && !rd_valid_o)
    else $error("visibility without enable");
  a_rdl_word: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE8]
    (op_i == PST_OP_RDL && !byte_mode_i) |=> rd_data_o == $past(prog_word_i[15:0]))
    else $error("read low word wrong");
  a_rdl_byte: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE9]
    (op_i == PST_OP_RDL && byte_mode_i) |=> rd_data_o ==
      {8'h00, ($past(table_ea_i[0]) ? $past(prog_word_i[15:8]) : $past(prog_word_i[7:0]))})
    else $error("read low byte wrong");
  a_rdh_word: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE10]
    (op_i == PST_OP_RDH && (!byte_mode_i || !table_ea_i[0]))
      |=> rd_data_o == {8'h00, $past(prog_word_i[23:16])})
    else $error("read high wrong");
  a_rdh_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE11]
    (op_i == PST_OP_RDH && byte_mode_i && table_ea_i[0]) |=> rd_data_o == 16'h0000)
    else $error("read high odd byte not zero");
  a_high_lane: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE12] [RULE13]
    (op_i == PST_OP_WTL) |=> prog_wr_o && !prog_lanes_o[2])
    else $error("low write touched upper byte");
  // a pc with its top bit set would land above the user ceiling
  a_user_range: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE4]
    (is_fetch && pc_i[PST_PC_W-1]) |=> range_err_o && !prog_rd_o)
    else $error("user range not enforced");
  a_table_no_err: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE4]
    is_table |=> !range_err_o)
    else $error("table op flagged out of range");

  // write path: only the lanes named by the op may move
  a_wth_data: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE12]
    (op_i == PST_OP_WTH) |=> prog_wr_o && prog_lanes_o == 3'b100
      && prog_wdata_o[23:16] == $past(wr_data_i[7:0]))
    else $error("high write lane or data wrong");
  a_wtl_data: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE13]
    (op_i == PST_OP_WTL && !byte_mode_i)
      |=> prog_lanes_o == 3'b011 && prog_wdata_o[15:0] == $past(wr_data_i))
    else $error("low write lane or data wrong");
  a_write_quiet: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE13]
    is_write |=> !prog_rd_o && !rd_valid_o)
    else $error("write also raised a read");

  // read and quiet cycles
  a_read_strobe: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE2]
    (op_i == PST_OP_RDL || op_i == PST_OP_RDH) |=> prog_rd_o && rd_valid_o && !prog_wr_o)
    else $error("table read strobes wrong");
  a_vis_data: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE14]
    vis_req |=> rd_valid_o && rd_data_o == $past(prog_word_i[15:0]))
    else $error("visibility data wrong");
  a_vis_no_cfg: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE6]
    vis_req |=> !config_space_o && !prog_addr_o[23])
    else $error("visibility reached configuration space");
  a_fetch_no_data: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE6]
    is_fetch |=> !rd_valid_o && !config_space_o)
    else $error("fetch raised data valid or config space");
  a_addr_align: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE7]
    (op_i != PST_OP_NONE) |=> !prog_addr_o[0])
    else $error("program address not word aligned");
  a_idle_quiet: assert property (@(posedge clk_i) disable iff (!reset_n_i)  // [RULE2]
    (op_i == PST_OP_NONE) |=> !prog_rd_o && !prog_wr_o && !rd_valid_o && !vis_hit_o)
    else $error("strobe without a request");

  c_vis_read:  cover property (@(posedge clk_i) vis_req ##1 rd_valid_o);
  c_rdh_byte:  cover property (@(posedge clk_i) op_i == PST_OP_RDH && byte_mode_i);
  c_cfg_table: cover property (@(posedge clk_i) is_table && table_page_register_i[7]);
  c_wth:       cover property (@(posedge clk_i) op_i == PST_OP_WTH ##1 prog_wr_o);
  c_fetch_err: cover property (@(posedge clk_i) is_fetch ##1 range_err_o);
endmodule : pst_access

// file: test/pst_mem_model.sv
// program memory model for the table access bench
// assumes the bench presents the word address that it expects the block to use
module pst_mem_model
  import pst_pkg::*;
(
  input  wire logic [23:0] addr_i,
  output logic      [23:0] word_o
);
  // whole 24-bit word per address; every byte moves with the address, so a lane mix-up shows
  assign word_o = {addr_i[23:16] ^ addr_i[8:1] ^ 8'hc3, addr_i[15:0] ^ 16'h5a96};
endmodule : pst_mem_model

// file: test/tb_program_space_table_access.sv
// bench for the program space table access block
// assumes inputs driven at the falling edge; results checked one cycle after the request
module tb_program_space_table_access;
  timeunit 1ns;
  timeprecision 1ps;
  import pst_pkg::*;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
  logic        clk_i, reset_n_i, byte_mode_i, program_space_visibility_i;
  pst_op_t     op_i;
  logic [22:0] pc_i;
  logic [15:0] table_ea_i, data_ea_i, wr_data_i, rd_data_o;
  logic [7:0]  table_page_register_i, visibility_page_register_i;
  logic [23:0] prog_word_i, mem_addr, prog_addr_o, prog_wdata_o;
  logic [2:0]  prog_lanes_o;
  logic        prog_rd_o, prog_wr_o, config_space_o, rd_valid_o, vis_hit_o, range_err_o;
  int          miscompares = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [23:0] w;
  pst_mem_model mem (.addr_i(mem_addr), .word_o(prog_word_i));
  pst_access dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .op_i(op_i), .byte_mode_i(byte_mode_i),
    .pc_i(pc_i), .table_ea_i(table_ea_i), .data_ea_i(data_ea_i), .wr_data_i(wr_data_i),
    .table_page_register_i(table_page_register_i), .prog_word_i(prog_word_i),
    .visibility_page_register_i(visibility_page_register_i),
    .program_space_visibility_i(program_space_visibility_i), .prog_addr_o(prog_addr_o),
    .prog_rd_o(prog_rd_o), .prog_wr_o(prog_wr_o), .prog_lanes_o(prog_lanes_o),
    .prog_wdata_o(prog_wdata_o), .config_space_o(config_space_o), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .vis_hit_o(vis_hit_o), .range_err_o(range_err_o));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // a hang ends the run as a failure instead of running on
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end
  // presents one request for one cycle, back to back with the next
  task automatic issue(input pst_op_t op, input logic bm, input logic [15:0] ea,
                       input logic [23:0] a);
    op_i = op;
    byte_mode_i = bm;
    table_ea_i = ea;
    data_ea_i = ea;
    mem_addr = a;
    @(negedge clk_i);
    w = prog_word_i;
  endtask : issue
  // six table read forms in user and configuration space; visibility armed but must stay idle
  task automatic t_table_read();
    logic [15:0] ea, exp;
    logic [7:0]  pg;
    program_space_visibility_i = 1'b1;
    for (int p = 0; p < 2; p++) begin
      pg = (p == 0) ? 8'h12 : 8'h85;
      table_page_register_i = pg;
      for (int k = 0; k < 6; k++) begin
        ea = 16'hca6c | 16'(k % 3 == 2);
        issue((k < 3) ? PST_OP_RDL : PST_OP_RDH, k % 3 != 0, ea, {pg, ea[15:1], 1'b0});
        case (k)
          0: exp = w[15:0];
          1: exp = {8'h00, w[7:0]};
          2: exp = {8'h00, w[15:8]};
          3, 4: exp = {8'h00, w[23:16]};
          default: exp = 16'h0000;
        endcase
        `CHK(rd_data_o, exp)
        `CHK(prog_addr_o, {pg, ea[15:1], 1'b0})
        `CHK(config_space_o, pg[7])
        `CHK({prog_rd_o, rd_valid_o, vis_hit_o, prog_wr_o}, 4'b1100)
      end
    end
  endtask : t_table_read
  // word writes to the low word space and the high byte space, then byte writes to each low lane
  task automatic t_table_write();
    table_page_register_i = 8'h81;
    wr_data_i = 16'hb7e4;
    issue(PST_OP_WTL, 1'b0, 16'h2468, 24'h812468);
    `CHK({prog_wr_o, prog_rd_o, prog_lanes_o}, 5'b10011)
    `CHK(prog_wdata_o[15:0], 16'hb7e4)
    `CHK({config_space_o, prog_addr_o}, 25'h1812468)
    issue(PST_OP_WTH, 1'b0, 16'h2468, 24'h812468);
    `CHK({prog_wr_o, prog_lanes_o}, 4'b1100)
    `CHK(prog_wdata_o[23:16], 8'he4)
    issue(PST_OP_WTL, 1'b1, 16'h2469, 24'h812468);
    `CHK({prog_wr_o, prog_rd_o, prog_lanes_o}, 5'b10010)
    issue(PST_OP_WTL, 1'b1, 16'h2468, 24'h812468);
    `CHK({prog_wr_o, prog_rd_o, prog_lanes_o}, 5'b10001)
  endtask : t_table_write
  // fetches step by two up to the user ceiling; one word past it is refused
  task automatic t_fetch();
    logic [22:0] pcs [4] = '{23'h000000, 23'h000001, 23'h3fffff, 23'h400000};
    table_page_register_i = 8'h80;
    for (int i = 0; i < 4; i++) begin
      pc_i = pcs[i];
      issue(PST_OP_FETCH, 1'b1, 16'h0000, {pcs[i], 1'b0});
      `CHK({range_err_o, prog_rd_o}, {i == 3, i != 3})
      if (i < 3) `CHK(prog_addr_o, {pcs[i], 1'b0})
      else `CHK(prog_addr_o[23], 1'b0)
      `CHK({config_space_o, rd_valid_o}, 2'b00)
    end
  endtask : t_fetch
  // visibility hit, then a low address and a disabled enable, both refused
  task automatic t_visibility();
    visibility_page_register_i = 8'h9b;
    program_space_visibility_i = 1'b1;
    issue(PST_OP_DATA, 1'b0, 16'hc3a4, {1'b0, 8'h9b, 15'h43a4});
    `CHK({vis_hit_o, rd_valid_o, prog_rd_o}, 3'b111)
    `CHK(prog_addr_o, {1'b0, 8'h9b, 15'h43a4})
    `CHK(rd_data_o, w[15:0])
    issue(PST_OP_DATA, 1'b0, 16'h43a4, 24'h0043a4);
    `CHK({vis_hit_o, rd_valid_o, prog_rd_o}, 3'b000)
    program_space_visibility_i = 1'b0;
    issue(PST_OP_DATA, 1'b0, 16'hc3a4, {1'b0, 8'h9b, 15'h43a4});
    `CHK({vis_hit_o, rd_valid_o, prog_rd_o}, 3'b000)
  endtask : t_visibility
  initial begin
    reset_n_i = 1'b0;
    op_i = PST_OP_NONE;
    {byte_mode_i, program_space_visibility_i, pc_i, table_ea_i, data_ea_i} = '0;
    {wr_data_i, table_page_register_i, visibility_page_register_i, mem_addr} = '0;
    repeat (16) @(negedge clk_i);
    reset_n_i = 1'b1;
    @(negedge clk_i);
    `CHK({prog_rd_o, prog_wr_o, rd_valid_o, vis_hit_o, range_err_o}, 5'b00000)
    t_table_read();
    t_table_write();
    t_fetch();
    t_visibility();
    complete_run();
  end
endmodule : tb_program_space_table_access
